// File: motion_record_defines.svh
// Byte offsets, field positions and limits of the axis part of the record.
`ifndef MOTION_RECORD_DEFINES_SVH
`define MOTION_RECORD_DEFINES_SVH

`define RECORD_FIRST_BYTE     9'd190
`define RECORD_LAST_BYTE      9'd369
`define AXIS_D_START          9'd190
`define AXIS_E_START          9'd228
`define AXIS_F_START          9'd264
`define AXIS_G_START          9'd298
`define AXIS_H_START          9'd334
`define AXIS_COUNT            5
`define AXIS_STD_BITS         288
`define AXIS_BLOCK_BYTES      8'h24
`define D_PAD_FIRST           6'd2
`define D_PAD_LAST            6'd3
`define D_PAD_BYTES           6'd2
`define F_AUX_SHORT_END       6'd18
`define F_AUX_DROPPED_BYTES   6'd2
`define VELOCITY_SCALE_SHIFT  6
`define TORQUE_LIMIT          32'sd32767
`define FIFO_DEPTH            32
`define FIFO_WIDTH            9

`endif

// File: motion_record_pkg.sv
// Types shared by the axis record framer, the host model and the bench.
package motion_record_pkg;

  typedef struct packed {
    logic move_in_progress;
    logic relative_move_mode;
    logic absolute_move_mode;
    logic edge_search_command;
    logic homing_command;
    logic homing_phase1_done;
    logic homing_phase2_or_index;
    logic coordinated_mode;
    logic negative_move;
    logic contour_mode;
    logic slewing;
    logic stopping;
    logic final_decel;
    logic latch_armed;
    logic homing_phase3_active;
    logic motor_off;
  } axis_status_type;

  typedef struct packed {
    logic latch_occurred;
    logic latch_level;
    logic forward_limit;
    logic reverse_limit;
    logic home_input;
    logic stepper_mode;
  } axis_switch_type;

  typedef struct packed {
    logic move_in_progress;
    logic slewing;
    logic stopping;
    logic final_decel;
  } plane_flags_type;

  typedef struct packed {
    axis_status_type    status;
    axis_switch_type    switches;
    logic [7:0]         stop_code;
    logic signed [31:0] reference_pos;
    logic signed [31:0] motor_pos;
    logic signed [31:0] position_error;
    logic signed [31:0] auxiliary_pos;
    logic signed [31:0] velocity_query;
    logic signed [31:0] torque_raw;
    logic signed [15:0] analog_in;
    logic [7:0]         hall_state;
    logic signed [31:0] user_variable;
  } axis_input_type;

  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } record_byte_type;

  typedef enum logic {IDLE, SEND} framer_state_type;

endpackage : motion_record_pkg

// File: byte_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;

  wire full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire empty = (wr_q == rd_q);
  wire push  = in_valid && !full;
  wire pop   = out_valid && out_ready;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end

  // Storage needs no reset: nothing reads a slot before it is written.
  always_ff @(posedge clock) begin
    if (push) mem_q[wr_q[AW-1:0]] <= in_data;
  end

endmodule : byte_fifo

// File: axis_record_framer.sv
// Framer for axis blocks D to H of the status record, with side encoders.
//
// Summary of operation
// - D block: status word at 190, switches at 194, stop code at 195.
// - D positions, velocity, torque as signed longs 196-219, analog 220-221.
// - D hall state at 222, reserved byte 223, user variable 224-227.
// - E, F, G repeat the field order from bytes 228, 264 and 298.
// - H block starts at 334 and ends the record at byte 369.
// - Thread status byte: bit n set while thread n runs.
// - Plane status: bits 15, 5, 4, 3 only; other bits zero.
// - Axis status bits 15 to 8 carry motion mode and homing flags.
// - Axis status bits 7 to 0 carry direction, profile and motor flags.
// - Switch byte: latch, latch level, limits, home, stepper; 5:4 zero.
// - Velocity field is sixty-four times the velocity query value, saturated at the signed 32-bit limits.
// - Torque is clamped to minus 32767 through plus 32767.
// - Size query answers one byte: 36, the bytes in an E, G or H axis block.
`include "motion_record_defines.svh"

module axis_record_framer (
  input  wire logic                             clock,
  input  wire logic                             rstn,
  input  wire motion_record_pkg::axis_input_type axis_in [`AXIS_COUNT],
  input  wire logic                       [7:0] thread_running,
  input  wire motion_record_pkg::plane_flags_type plane_in [2],
  input  wire logic                             record_request,
  input  wire logic                             record_ready,
  input  wire logic                             size_query,
  output motion_record_pkg::record_byte_type    record_byte_q,
  output logic                                  record_valid_q,
  output logic                                  record_busy_q,
  output logic                            [7:0] thread_status_q,
  output logic                           [15:0] plane_status_q [2],
  output logic                            [7:0] axis_size_q,
  output logic                                  axis_size_valid_q
);
  import motion_record_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Field conditioning. Each axis is packed into one 36-byte vector whose
  // byte k is record byte k of a standard block; the low field bits sit at
  // the low byte so the stream leaves least significant byte first.

  logic [`AXIS_STD_BITS-1:0] std_vec [`AXIS_COUNT];
  logic signed [31:0]        vel_scaled [`AXIS_COUNT];
  logic signed [31:0]        torque_clamped [`AXIS_COUNT];

  for (genvar i = 0; i < `AXIS_COUNT; i++) begin : g_axis
    wire signed [37:0] vel_wide = 38'(axis_in[i].velocity_query)
                                  <<< `VELOCITY_SCALE_SHIFT;
    wire vel_over  = !vel_wide[37] && (vel_wide[36:31] != 6'h00);
    wire vel_under = vel_wide[37] && (vel_wide[36:31] != 6'h3f);
    wire signed [31:0] torque_in = axis_in[i].torque_raw;
    wire [15:0] status_word = 16'(axis_in[i].status);
    wire axis_switch_type sw = axis_in[i].switches;
    wire [7:0] switch_byte = {sw.latch_occurred, sw.latch_level, 2'b00,
                              sw.forward_limit, sw.reverse_limit,
                              sw.home_input, sw.stepper_mode};

    // Saturating rather than wrapping keeps the sign honest at extremes.
    assign vel_scaled[i] = vel_over  ? 32'sh7fffffff :
                           vel_under ? 32'sh80000000 :
                           32'(vel_wide);
    assign torque_clamped[i] =
      (torque_in > `TORQUE_LIMIT)  ? `TORQUE_LIMIT :
      (torque_in < -`TORQUE_LIMIT) ? -`TORQUE_LIMIT : torque_in;

    assign std_vec[i] = {axis_in[i].user_variable,
                         8'h00,
                         axis_in[i].hall_state,
                         axis_in[i].analog_in,
                         torque_clamped[i],
                         vel_scaled[i],
                         axis_in[i].auxiliary_pos,
                         axis_in[i].position_error,
                         axis_in[i].motor_pos,
                         axis_in[i].reference_pos,
                         axis_in[i].stop_code,
                         switch_byte,
                         status_word};
  end

  //////////////////////////////////////////////////////////////////////////
  // Record sequencer. A request snapshots all five axes so that the record
  // is coherent even while the motion logic keeps changing its inputs.

  framer_state_type          state_q;
  logic [8:0]                addr_q;
  logic [`AXIS_STD_BITS-1:0] snap_q [`AXIS_COUNT];
  logic                      fifo_in_ready;
  logic                      fifo_out_valid;
  record_byte_type           fifo_out_data;

  wire take     = (state_q == IDLE) && record_request;
  wire push     = (state_q == SEND) && fifo_in_ready;
  wire at_last  = (addr_q == `RECORD_LAST_BYTE);
  wire out_free = !record_valid_q || record_ready;
  wire pop      = fifo_out_valid && out_free;

  // Block selection by byte address; block sizes differ, so use starts.
  wire [2:0] axis_sel = (addr_q >= `AXIS_H_START) ? 3'd4 :
                        (addr_q >= `AXIS_G_START) ? 3'd3 :
                        (addr_q >= `AXIS_F_START) ? 3'd2 :
                        (addr_q >= `AXIS_E_START) ? 3'd1 : 3'd0;
  wire [8:0] start_sel = (axis_sel == 3'd4) ? `AXIS_H_START :
                         (axis_sel == 3'd3) ? `AXIS_G_START :
                         (axis_sel == 3'd2) ? `AXIS_F_START :
                         (axis_sel == 3'd1) ? `AXIS_E_START :
                         `AXIS_D_START;
  wire [5:0] rel_raw = 6'(addr_q - start_sel);

  // The D status word spans four bytes, two of them zero padding; the F
  // auxiliary position has only two bytes, so its high half is dropped.
  wire d_block = (axis_sel == 3'd0);
  wire f_block = (axis_sel == 3'd2);
  wire d_pad   = d_block && (rel_raw >= `D_PAD_FIRST)
                         && (rel_raw <= `D_PAD_LAST);
  wire [5:0] rel_std =
    (d_block && rel_raw > `D_PAD_LAST) ? rel_raw - `D_PAD_BYTES :
    (f_block && rel_raw >= `F_AUX_SHORT_END)
      ? rel_raw + `F_AUX_DROPPED_BYTES : rel_raw;

  wire [`AXIS_STD_BITS-1:0] sel_vec = snap_q[axis_sel];
  wire [7:0] byte_val = d_pad ? 8'h00 : sel_vec[8*rel_std +: 8];
  wire record_byte_type push_data = '{last: at_last, data: byte_val};

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= IDLE;
      addr_q  <= `RECORD_FIRST_BYTE;
    end else if (take) begin
      state_q <= SEND;
      addr_q  <= `RECORD_FIRST_BYTE;
    end else if (push) begin
      state_q <= at_last ? IDLE : SEND;
      addr_q  <= at_last ? `RECORD_FIRST_BYTE : addr_q + 9'd1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `AXIS_COUNT; i++) snap_q[i] <= '0;
    end else if (take) begin
      for (int i = 0; i < `AXIS_COUNT; i++) snap_q[i] <= std_vec[i];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) record_busy_q <= 1'b0;
    else record_busy_q <= (state_q == SEND) || fifo_out_valid
                          || record_valid_q;
  end

  //////////////////////////////////////////////////////////////////////////
  // Output buffer. The FIFO absorbs host stalls; its full flag halts the
  // sequencer, and a final register keeps the outputs on flip-flops.

  byte_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rstn      (rstn),
    .in_valid  (state_q == SEND),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data),
    .out_valid (fifo_out_valid),
    .out_ready (out_free),
    .out_data  (fifo_out_data)
  );

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      record_valid_q <= 1'b0;
      record_byte_q  <= '0;
    end else if (out_free) begin
      record_valid_q <= fifo_out_valid;
      if (pop) record_byte_q <= fifo_out_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Side encoders and the record-size query.

  wire [15:0] plane_word [2];
  for (genvar p = 0; p < 2; p++) begin : g_plane
    assign plane_word[p] = {plane_in[p].move_in_progress, 9'h000,
                            plane_in[p].slewing, plane_in[p].stopping,
                            plane_in[p].final_decel, 3'h0};
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      thread_status_q   <= 8'h00;
      plane_status_q[0] <= 16'h0000;
      plane_status_q[1] <= 16'h0000;
      axis_size_q       <= 8'h00;
      axis_size_valid_q <= 1'b0;
    end else begin
      thread_status_q   <= thread_running;
      plane_status_q[0] <= plane_word[0];
      plane_status_q[1] <= plane_word[1];
      axis_size_valid_q <= size_query;
      if (size_query) axis_size_q <= `AXIS_BLOCK_BYTES;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_take;
    take;
  endsequence

  sequence s_first_push;
    push && (addr_q == `RECORD_FIRST_BYTE);
  endsequence

  // A full buffer must freeze the address, or bytes would be skipped.
  sequence s_stall;
    (state_q == SEND) && !fifo_in_ready;
  endsequence

  a_record_start: assert property (
    s_take |=> s_first_push or (!push && addr_q == 9'd190))
    else $error("record does not start at byte 190");

  a_switch_byte: assert property (
    push && addr_q == 9'd194
    |-> byte_val[5:4] == 2'b00 && byte_val == snap_q[0][23:16])
    else $error("D switches byte wrong");

  a_stop_code: assert property (
    push && addr_q == 9'd195 |-> byte_val == snap_q[0][31:24])
    else $error("D stop code byte wrong");

  a_status_pad: assert property (
    push && (addr_q == 9'd192 || addr_q == 9'd193) |-> byte_val == 8'h00)
    else $error("D status padding not zero");

  a_ref_low: assert property (
    push && addr_q == 9'd196 |-> byte_val == snap_q[0][39:32])
    else $error("D reference position low byte wrong");

  a_d_velocity: assert property (
    push && addr_q == 9'd212 |-> byte_val == snap_q[0][167:160])
    else $error("D velocity low byte misplaced");

  a_d_torque: assert property (
    push && addr_q == 9'd216 |-> byte_val == snap_q[0][199:192])
    else $error("D torque low byte misplaced");

  a_d_analog: assert property (
    push && addr_q == 9'd220 |-> byte_val == snap_q[0][231:224])
    else $error("D analog input low byte misplaced");

  a_d_hall: assert property (
    push && addr_q == 9'd222 |-> byte_val == snap_q[0][247:240])
    else $error("D hall state byte misplaced");

  a_reserved_zero: assert property (
    push && (addr_q == 9'd223 || addr_q == 9'd365) |-> byte_val == 8'h00)
    else $error("reserved byte not zero");

  a_d_user_top: assert property (
    push && addr_q == 9'd227 |-> byte_val == snap_q[0][287:280])
    else $error("D user variable top byte misplaced");

  a_e_start: assert property (
    push && addr_q == 9'd228 |-> byte_val == snap_q[1][7:0])
    else $error("E status low byte misplaced");

  a_f_aux_high: assert property (
    push && addr_q == 9'd281 |-> byte_val == snap_q[2][143:136])
    else $error("F auxiliary position byte misplaced");

  a_f_velocity: assert property (
    push && addr_q == 9'd282 |-> byte_val == snap_q[2][167:160])
    else $error("F velocity low byte misplaced");

  a_f_end: assert property (
    push && addr_q == 9'd297 |-> byte_val == snap_q[2][287:280])
    else $error("F block end misplaced");

  a_axis_start: assert property (
    push && addr_q == 9'd298 |-> byte_val == snap_q[3][7:0])
    else $error("G status low byte misplaced");

  a_g_end: assert property (
    push && addr_q == 9'd333 |-> byte_val == snap_q[3][287:280])
    else $error("G block end misplaced");

  a_h_start: assert property (
    push && addr_q == 9'd334 |-> byte_val == snap_q[4][7:0])
    else $error("H status low byte misplaced");

  a_record_end: assert property (
    push && at_last
    |-> byte_val == snap_q[4][287:280] ##1 state_q == IDLE)
    else $error("record does not end with H user variable");

  a_fifo_stall: assert property (
    s_stall |=> $stable(addr_q))
    else $error("address moved while the buffer was full");

  a_busy_send: assert property (
    state_q == SEND |=> record_busy_q)
    else $error("busy low while a record is sent");

  a_byte_hold: assert property (
    record_valid_q && !record_ready
    |=> record_valid_q && $stable(record_byte_q))
    else $error("record byte changed before it was taken");

  a_thread_map: assert property (
    1'b1 |=> thread_status_q == $past(thread_running))
    else $error("thread status does not follow running threads");

  a_plane_unused: assert property (
    (plane_status_q[0] & 16'h7fc7) == 16'h0
    && (plane_status_q[1] & 16'h7fc7) == 16'h0)
    else $error("plane status unused bits set");

  a_plane_move: assert property (
    1'b1 |=> plane_status_q[0][15] == $past(plane_in[0].move_in_progress))
    else $error("plane move bit does not follow its flag");

  a_velocity_scale: assert property (
    !g_axis[0].vel_over && !g_axis[0].vel_under
    |-> vel_scaled[0] == axis_in[0].velocity_query * 64)
    else $error("velocity not scaled by 64");

  a_velocity_sat: assert property (
    g_axis[0].vel_over |-> vel_scaled[0] == 32'sh7fffffff)
    else $error("velocity overflow not saturated");

  a_torque_range: assert property (
    torque_clamped[1] <= 32'sd32767 && torque_clamped[1] >= -32'sd32767)
    else $error("torque out of range");

  a_torque_pass: assert property (
    axis_in[1].torque_raw <= 32'sd32767
    && axis_in[1].torque_raw >= -32'sd32767
    |-> torque_clamped[1] == axis_in[1].torque_raw)
    else $error("torque in range was altered");

  a_size_answer: assert property (
    size_query |=> axis_size_valid_q && axis_size_q == 8'h24)
    else $error("size query answer wrong");

  a_size_single: assert property (
    !size_query |=> !axis_size_valid_q)
    else $error("size answer without a query");

endmodule : axis_record_framer

// File: record_host.sv
// Host model that requests the axis record and collects its bytes.
module record_host
  import motion_record_pkg::*;
(
  input  wire logic                       clock,
  input  motion_record_pkg::record_byte_type record_byte_q,
  input  wire logic                       record_valid_q,
  output logic                            record_request,
  output logic                            record_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  record_byte_type got [$];

  initial begin
    record_request = 1'b0;
    record_ready   = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // A slow host refuses everything for 40 cycles so the buffer fills up,
  // then takes one byte in three; a poke repeats the request mid-record.
  task automatic fetch(input bit slow, input bit poke);
    int cyc;
    got.delete();
    cyc = 0;
    @(posedge clock);
    #1 record_request = 1'b1;
    record_ready = !slow;
    @(posedge clock);
    #1 record_request = 1'b0;
    while (got.size() < 180 && cyc < 4000) begin
      @(posedge clock);
      if (record_valid_q && record_ready) begin
        got.push_back(record_byte_q);
      end
      cyc++;
      // Ready is left high once the whole record is in.
      #1 record_ready = !slow || got.size() >= 180
                        || (cyc > 40 && cyc % 3 == 0);
      record_request = poke && got.size() == 50;
    end
  endtask : fetch
endmodule : record_host

// File: tb_motion_status_record_axes.sv
// Self-checking bench for the axis part of the status record framer.
module tb_motion_status_record_axes;
  timeunit 1ns;
  timeprecision 1ps;
  import motion_record_pkg::*;

  logic            clock;
  logic            rstn;
  axis_input_type  axis_in [5];
  logic      [7:0] thread_running;
  plane_flags_type plane_in [2];
  logic            size_query;
  logic            record_request;
  logic            record_ready;
  record_byte_type record_byte_q;
  logic            record_valid_q;
  logic            record_busy_q;
  logic      [7:0] thread_status_q;
  logic     [15:0] plane_status_q [2];
  logic      [7:0] axis_size_q;
  logic            axis_size_valid_q;
  logic      [7:0] expect_q [$];
  int              bad_count;
  int              n_tests;

  axis_record_framer DUT (
    .clock             (clock),
    .rstn              (rstn),
    .axis_in           (axis_in),
    .thread_running    (thread_running),
    .plane_in          (plane_in),
    .record_request    (record_request),
    .record_ready      (record_ready),
    .size_query        (size_query),
    .record_byte_q     (record_byte_q),
    .record_valid_q    (record_valid_q),
    .record_busy_q     (record_busy_q),
    .thread_status_q   (thread_status_q),
    .plane_status_q    (plane_status_q),
    .axis_size_q       (axis_size_q),
    .axis_size_valid_q (axis_size_valid_q)
  );

  record_host host (
    .clock          (clock),
    .record_byte_q  (record_byte_q),
    .record_valid_q (record_valid_q),
    .record_request (record_request),
    .record_ready   (record_ready)
  );

  always #20 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] expv);
    n_tests++;
    if (seen !== expv) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, expv, seen);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////
  // Operand k picks a velocity and torque corner case per axis.
  function automatic axis_input_type mk(input int k);
    axis_input_type a;
    a.status         = 16'(32'h8421 * (k + 1));
    a.switches       = 6'(k * 11);
    a.stop_code      = 8'(k + 3);
    a.reference_pos  = 32'(k * 32'h0102_0304);
    a.motor_pos      = -a.reference_pos;
    a.position_error = 32'h8000_0000 | 32'(k);
    a.auxiliary_pos  = 32'h1357_9bdf + 32'(k);
    a.analog_in      = 16'h8000 + 16'(k * 16'h1111);
    a.hall_state     = 8'(k * 5);
    a.user_variable  = 32'hdead_0000 + 32'(k);
    case (k % 5)
      0: begin a.velocity_query = 32'sh0400_0000; a.torque_raw = 40000; end
      1: begin a.velocity_query = -32'sh0400_0001; a.torque_raw = -40000; end
      2: begin a.velocity_query = 32'sh01ff_ffff; a.torque_raw = 32767; end
      3: begin a.velocity_query = -3; a.torque_raw = -32768; end
      default: begin a.velocity_query = 100; a.torque_raw = 0; end
    endcase
    return a;
  endfunction : mk

  task automatic add(input logic [31:0] v, input int n);
    for (int b = 0; b < n; b++) expect_q.push_back(v[8*b +: 8]);
  endtask : add

  task automatic build(input int base);
    axis_input_type a;
    longint         v;
    int             t;
    expect_q.delete();
    for (int i = 0; i < 5; i++) begin
      a = mk(base + i);
      axis_in[i] = a;
      v = longint'(a.velocity_query) * 64;
      if (v > 64'sh7fff_ffff) v = 64'sh7fff_ffff;
      if (v < -64'sh8000_0000) v = -64'sh8000_0000;
      t = a.torque_raw;
      if (t > 32767) t = 32767;
      if (t < -32767) t = -32767;
      add(32'(a.status), 2);
      if (i == 0) add(32'h0, 2);
      add({a.switches[5:4], 2'b00, a.switches[3:0]}, 1);
      add(a.stop_code, 1);
      add(a.reference_pos, 4);
      add(a.motor_pos, 4);
      add(a.position_error, 4);
      add(a.auxiliary_pos, (i == 2) ? 2 : 4);
      add(32'(v), 4);
      add(32'(t), 4);
      add(32'(a.analog_in), 2);
      add(a.hall_state, 1);
      add(32'h0, 1);
      add(a.user_variable, 4);
    end
  endtask : build

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    check("valid", 32'(record_valid_q), 32'h0);
    check("busy", 32'(record_busy_q), 32'h0);
    check("size_valid", 32'(axis_size_valid_q), 32'h0);
    $display("test reset done");
  endtask : test_reset

  task automatic test_encoders;
    logic [15:0] pw [4] = '{16'h8000, 16'h0020, 16'h0010, 16'h0008};
    for (int n = 0; n < 8; n++) begin
      thread_running = 8'h01 << n;
      plane_in[0]    = 4'h8 >> (n % 4);
      plane_in[1]    = ~(4'h8 >> (n % 4));
      @(posedge clock);
      #1;
      check("thread", 32'(thread_status_q), 32'h1 << n);
      check("plane_s", 32'(plane_status_q[0]), 32'(pw[n % 4]));
      check("plane_t", 32'(plane_status_q[1]),
            32'(16'h8038 ^ pw[n % 4]));
    end
    $display("test encoders done");
  endtask : test_encoders

  task automatic test_size;
    @(posedge clock);
    #1 size_query = 1'b1;
    @(posedge clock);
    #1 size_query = 1'b0;
    check("size_valid", 32'(axis_size_valid_q), 32'h1);
    check("size", 32'(axis_size_q), 32'h24);
    @(posedge clock);
    #1;
    check("size_valid", 32'(axis_size_valid_q), 32'h0);
    check("size", 32'(axis_size_q), 32'h24);
    $display("test size done");
  endtask : test_size

  // The whole record is compared byte by byte, then the block must go idle.
  task automatic test_record(input bit slow, input bit poke, input int base);
    build(base);
    host.fetch(slow, poke);
    check("count", 32'(host.got.size()), 32'd180);
    for (int i = 0; i < host.got.size(); i++) begin
      check($sformatf("byte %0d", 190 + i), 32'(host.got[i].data),
            32'(expect_q[i]));
      check("last", 32'(host.got[i].last), 32'(i == 179));
    end
    repeat (2) @(posedge clock);
    #1;
    check("busy", 32'(record_busy_q), 32'h0);
    repeat (6) begin
      @(posedge clock);
      #1;
      check("valid idle", 32'(record_valid_q), 32'h0);
    end
    $display("test record slow=%0d poke=%0d done", slow, poke);
  endtask : test_record

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock          = 1'b0;
    rstn           = 1'b0;
    thread_running = 8'h00;
    size_query     = 1'b0;
    bad_count      = 0;
    n_tests        = 0;
    plane_in[0]    = '0;
    plane_in[1]    = '0;
    build(0);
    repeat (2) @(posedge clock);
    #1 rstn = 1'b1;
    test_reset();
    test_encoders();
    test_size();
    test_record(1'b0, 1'b0, 0);
    test_record(1'b1, 1'b1, 7);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    summarize();
  end
endmodule : tb_motion_status_record_axes
